// file: smc_consts.svh
// constants for the standby and module clock stop block
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define SMC_ADR_W 4
`define SMC_OFS_MODE 4'h0
`define SMC_OFS_CORE 4'h4
`define SMC_OFS_SER 4'h8
`define SMC_REG_RST 8'h00

// ----------------------------------------------------------------
// writable masks; all other bits read as zero
// ----------------------------------------------------------------
`define SMC_MODE_MASK 8'h86
`define SMC_CORE_MASK 8'hFD
`define SMC_SER_MASK 8'h0F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SMC_B_DEEP_STANDBY_SELECT 7
`define SMC_B_TMU 2
`define SMC_B_RTC 1
`define SMC_B_DBG 7
`define SMC_B_UBC 6
`define SMC_B_DMA 5
`define SMC_B_DSP 4
`define SMC_B_TLB 3
`define SMC_B_CACHE 2
`define SMC_B_XY 0
`define SMC_B_SSP1 3
`define SMC_B_SSP0 2
`define SMC_B_ASP1 1
`define SMC_B_ASP0 0

// ----------------------------------------------------------------
// gate vector indices
// ----------------------------------------------------------------
`define SMC_NGATE 13
`define SMC_G_TMU 0
`define SMC_G_RTC 1
`define SMC_G_DBG 2
`define SMC_G_UBC 3
`define SMC_G_DMA 4
`define SMC_G_DSP 5
`define SMC_G_TLB 6
`define SMC_G_CACHE 7
`define SMC_G_XY 8
`define SMC_G_SSP1 9
`define SMC_G_SSP0 10
`define SMC_G_ASP1 11
`define SMC_G_ASP0 12

`endif

// file: smc_pkg.sv
// types for the standby and module clock stop block
package smc_pkg;
	typedef enum logic [3:0] {
		SMC_ST_RESET = 4'h1,
		SMC_ST_RUN = 4'h2,
		SMC_ST_SLEEP = 4'h4,
		SMC_ST_STANDBY = 4'h8
	} smc_state_t;
endpackage

// file: smc_gate_if.sv
// carrier between the register block and the clock gate stage
`timescale 1ns/10ps
interface smc_gate_if;
	logic [12:0] stop;
	logic halt_all;
	logic [12:0] run;
	modport ctrl (output stop, output halt_all, input run);
	modport gate (input stop, input halt_all, output run);
endinterface

// file: smc_gate.sv
// registered run enables for each module clock gate
`timescale 1ns/10ps
`include "smc_consts.svh"
module smc_gate #(
	parameter int NGATE = `SMC_NGATE
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	smc_gate_if.gate g
);
	import smc_pkg::*;

	logic [NGATE-1:0] next_run;
	logic [NGATE-1:0] run;

	// ----------------------------------------------------------------
	// per-gate enable
	// ----------------------------------------------------------------
	// enables change only at a rising edge; the downstream latch-based
	// cell samples them while the clock is low, so no pulse is cut short
	genvar i;
	generate
		for (i = 0; i < NGATE; i = i + 1) begin : gen_gate
			always_comb begin
				next_run[i] = !g.stop[i] && !g.halt_all;
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run <= '1;
		end else begin
			run <= next_run;
		end
	end

	assign g.run = run;

	run_follows_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(!rst_i) |-> (run == ~($past(g.stop) | {NGATE{$past(g.halt_all)}})))
		else $error("run enable does not follow stop bits");
	halt_all_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		g.halt_all ##1 !rst_i |-> run == '0)
		else $error("gate still open in standby");
endmodule

// file: smc_top.sv
// standby mode selection, processing state pins and module clock stop registers
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
`include "smc_consts.svh"
// How it works
// - three 8-bit registers, cleared only by power-on
// - mode bit 7 picks sleep or standby
// - reserved bits read zero, write zero
// - mode bit 2 stops timer unit clock
// - mode bit 1 stops real-time clock
// - core bit 7 stops debug interface clock
// - core bit 6 stops break controller clock
// - core bit 5 stops DMA controller clock
// - core bit 4 stops DSP clock
// - core bit 3 stops TLB clock
// - core bit 2 stops cache clock
// - core bit 0 stops X/Y memory clock
// - serial bit 3 stops sync port 1
// - serial bit 2 stops sync port 0
// - serial bit 1 stops async port 1
// - serial bit 0 stops async port 0
// - state pins: reset HH, sleep HL, standby LH
// - standby halts CPU, clocks and bus clock
// - stop ends by software clear or power-on
module smc_top (
	// clock and power-on reset
	input wire logic clk_i,
	input wire logic rst_i,
	// manual reset, sleep instruction, wake-up interrupt
	input wire logic manual_rst_i,
	input wire logic sleep_i,
	input wire logic wake_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`SMC_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// processing state and core clocks
	output logic proc_state_hi_o,
	output logic proc_state_lo_o,
	output logic cpu_halt_o,
	output logic bus_clk_run_o,
	// module clock run enables, index per gate vector
	output logic [`SMC_NGATE-1:0] module_clk_run_o
);
	import smc_pkg::*;

	smc_gate_if gif ();

	// ----------------------------------------------------------------
	// registers and bus slave
	// ----------------------------------------------------------------
	logic [7:0] standby_mode_control;
	logic [7:0] core_unit_stop_control;
	logic [7:0] serial_unit_stop_control;
	logic [7:0] next_mode;
	logic [7:0] next_core;
	logic [7:0] next_ser;
	logic [31:0] next_dat;
	logic next_ack;
	logic req;
	logic wr;

	always_comb begin
		req = wb_cyc_i && wb_stb_i && !wb_ack_o;
		wr = req && wb_we_i && wb_sel_i[0];
		next_ack = req;
		next_mode = standby_mode_control;
		next_core = core_unit_stop_control;
		next_ser = serial_unit_stop_control;
		next_dat = 32'h00000000;
		// stop bits change only on a software write; manual reset leaves them
		if (wr) begin
			case (wb_adr_i)
				`SMC_OFS_MODE: begin
					next_mode = wb_dat_i[7:0] & `SMC_MODE_MASK;
				end
				`SMC_OFS_CORE: begin
					next_core = wb_dat_i[7:0] & `SMC_CORE_MASK;
				end
				`SMC_OFS_SER: begin
					next_ser = wb_dat_i[7:0] & `SMC_SER_MASK;
				end
				default: begin
					next_mode = standby_mode_control;
				end
			endcase
		end
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				`SMC_OFS_MODE: begin
					next_dat = {24'h000000, standby_mode_control};
				end
				`SMC_OFS_CORE: begin
					next_dat = {24'h000000, core_unit_stop_control};
				end
				`SMC_OFS_SER: begin
					next_dat = {24'h000000, serial_unit_stop_control};
				end
				default: begin
					next_dat = 32'h00000000;
				end
			endcase
		end
	end

	// only the power-on reset clears the registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			standby_mode_control <= `SMC_REG_RST;
			core_unit_stop_control <= `SMC_REG_RST;
			serial_unit_stop_control <= `SMC_REG_RST;
			wb_dat_o <= 32'h00000000;
			wb_ack_o <= 1'b0;
		end else begin
			standby_mode_control <= next_mode;
			core_unit_stop_control <= next_core;
			serial_unit_stop_control <= next_ser;
			wb_dat_o <= next_dat;
			wb_ack_o <= next_ack;
		end
	end

	// ----------------------------------------------------------------
	// processing state
	// ----------------------------------------------------------------
	smc_state_t state;
	smc_state_t next_state;
	logic next_hi;
	logic next_lo;
	logic next_halt;
	logic next_bus_run;

	always_comb begin
		next_state = state;
		case (state)
			SMC_ST_RESET: begin
				next_state = SMC_ST_RUN;
			end
			SMC_ST_RUN: begin
				if (sleep_i) begin
					if (standby_mode_control[`SMC_B_DEEP_STANDBY_SELECT]) begin
						next_state = SMC_ST_STANDBY;
					end else begin
						next_state = SMC_ST_SLEEP;
					end
				end
			end
			SMC_ST_SLEEP: begin
				if (wake_i) begin
					next_state = SMC_ST_RUN;
				end
			end
			SMC_ST_STANDBY: begin
				if (wake_i) begin
					next_state = SMC_ST_RUN;
				end
			end
			default: begin
				next_state = SMC_ST_RESET;
			end
		endcase
		if (manual_rst_i) begin
			next_state = SMC_ST_RESET;
		end
		next_hi = (next_state == SMC_ST_RESET) || (next_state == SMC_ST_SLEEP);
		next_lo = (next_state == SMC_ST_RESET) || (next_state == SMC_ST_STANDBY);
		next_halt = (next_state != SMC_ST_RUN);
		next_bus_run = (next_state != SMC_ST_STANDBY);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= SMC_ST_RESET;
			proc_state_hi_o <= 1'b1;
			proc_state_lo_o <= 1'b1;
			cpu_halt_o <= 1'b1;
			bus_clk_run_o <= 1'b1;
		end else begin
			state <= next_state;
			proc_state_hi_o <= next_hi;
			proc_state_lo_o <= next_lo;
			cpu_halt_o <= next_halt;
			bus_clk_run_o <= next_bus_run;
		end
	end

	// ----------------------------------------------------------------
	// module clock stop vector
	// ----------------------------------------------------------------
	always_comb begin
		gif.stop[`SMC_G_TMU] = standby_mode_control[`SMC_B_TMU];
		gif.stop[`SMC_G_RTC] = standby_mode_control[`SMC_B_RTC];
		gif.stop[`SMC_G_DBG] = core_unit_stop_control[`SMC_B_DBG];
		gif.stop[`SMC_G_UBC] = core_unit_stop_control[`SMC_B_UBC];
		gif.stop[`SMC_G_DMA] = core_unit_stop_control[`SMC_B_DMA];
		gif.stop[`SMC_G_DSP] = core_unit_stop_control[`SMC_B_DSP];
		gif.stop[`SMC_G_TLB] = core_unit_stop_control[`SMC_B_TLB];
		gif.stop[`SMC_G_CACHE] = core_unit_stop_control[`SMC_B_CACHE];
		gif.stop[`SMC_G_XY] = core_unit_stop_control[`SMC_B_XY];
		gif.stop[`SMC_G_SSP1] = serial_unit_stop_control[`SMC_B_SSP1];
		gif.stop[`SMC_G_SSP0] = serial_unit_stop_control[`SMC_B_SSP0];
		gif.stop[`SMC_G_ASP1] = serial_unit_stop_control[`SMC_B_ASP1];
		gif.stop[`SMC_G_ASP0] = serial_unit_stop_control[`SMC_B_ASP0];
		// the rtc gate also closes in standby; it has no separate start control here
		gif.halt_all = (next_state == SMC_ST_STANDBY);
	end

	smc_gate #(
		.NGATE(`SMC_NGATE)
	) u_gate (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.g(gif.gate)
	);

	assign module_clk_run_o = gif.run;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	ack_after_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("request not answered next cycle");
	reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(standby_mode_control & ~`SMC_MODE_MASK) == 8'h00
		&& (core_unit_stop_control & ~`SMC_CORE_MASK) == 8'h00
		&& (serial_unit_stop_control & ~`SMC_SER_MASK) == 8'h00)
		else $error("reserved bit set");
	por_clears_regs_a: assert property (@(posedge clk_i)
		rst_i |=> standby_mode_control == 8'h00 && core_unit_stop_control == 8'h00
		&& serial_unit_stop_control == 8'h00)
		else $error("power-on reset did not clear registers");
	manual_keeps_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(manual_rst_i && !(wb_cyc_i && wb_stb_i)) |=> $stable(standby_mode_control)
		&& $stable(core_unit_stop_control) && $stable(serial_unit_stop_control))
		else $error("manual reset changed a register");
	sleep_target_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == SMC_ST_RUN && sleep_i && !manual_rst_i) |=>
		(state == ($past(standby_mode_control[`SMC_B_DEEP_STANDBY_SELECT]) ? SMC_ST_STANDBY : SMC_ST_SLEEP)))
		else $error("sleep entered the wrong mode");
	status_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
		{proc_state_hi_o, proc_state_lo_o} == (state == SMC_ST_RESET ? 2'h3 :
		state == SMC_ST_SLEEP ? 2'h2 : state == SMC_ST_STANDBY ? 2'h1 : 2'h0))
		else $error("state pins disagree with state");
	standby_halts_a: assert property (@(posedge clk_i) disable iff (rst_i)
		state == SMC_ST_STANDBY |-> cpu_halt_o && !bus_clk_run_o)
		else $error("standby left a clock running");
	stop_needs_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(serial_unit_stop_control[`SMC_B_ASP0]) |->
		$past(rst_i || (wb_cyc_i && wb_stb_i && wb_we_i)))
		else $error("stop bit cleared without a write");
	tmu_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		standby_mode_control[`SMC_B_TMU] ##1 standby_mode_control[`SMC_B_TMU]
		|-> !module_clk_run_o[`SMC_G_TMU])
		else $error("timer unit clock not stopped");
endmodule

// file: tb_smc_top.sv
// self-checking bench for the standby and module clock stop block
`timescale 1ns/10ps
`include "smc_consts.svh"
module tb_smc_top;
	logic clk_i, rst_i, manual_rst_i, sleep_i, wake_i;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic proc_state_hi_o, proc_state_lo_o, cpu_halt_o, bus_clk_run_o;
	logic [12:0] module_clk_run_o;
	int n_fail = 0;
	int n_tests = 0;
	typedef struct {logic [3:0] adr; logic [7:0] wd; logic [7:0] rd; logic [12:0] run;} smc_row_t;
	// write, expected readback, expected run enables (all others still running)
	smc_row_t rows [18] = '{
		'{`SMC_OFS_MODE, 8'h04, 8'h04, 13'h1FFE}, '{`SMC_OFS_MODE, 8'h02, 8'h02, 13'h1FFD},
		'{`SMC_OFS_MODE, 8'hFF, 8'h86, 13'h1FFC}, '{`SMC_OFS_MODE, 8'h00, 8'h00, 13'h1FFF},
		'{`SMC_OFS_CORE, 8'h80, 8'h80, 13'h1FFB}, '{`SMC_OFS_CORE, 8'h40, 8'h40, 13'h1FF7},
		'{`SMC_OFS_CORE, 8'h20, 8'h20, 13'h1FEF}, '{`SMC_OFS_CORE, 8'h10, 8'h10, 13'h1FDF},
		'{`SMC_OFS_CORE, 8'h08, 8'h08, 13'h1FBF}, '{`SMC_OFS_CORE, 8'h04, 8'h04, 13'h1F7F},
		'{`SMC_OFS_CORE, 8'h01, 8'h01, 13'h1EFF}, '{`SMC_OFS_CORE, 8'h02, 8'h00, 13'h1FFF},
		'{`SMC_OFS_SER, 8'h08, 8'h08, 13'h1DFF}, '{`SMC_OFS_SER, 8'h04, 8'h04, 13'h1BFF},
		'{`SMC_OFS_SER, 8'h02, 8'h02, 13'h17FF}, '{`SMC_OFS_SER, 8'h01, 8'h01, 13'h0FFF},
		'{`SMC_OFS_SER, 8'hF0, 8'h00, 13'h1FFF}, '{4'hC, 8'hFF, 8'h00, 13'h1FFF}
	};

	smc_top DUT (
		.clk_i(clk_i), .rst_i(rst_i), .manual_rst_i(manual_rst_i), .sleep_i(sleep_i),
		.wake_i(wake_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .proc_state_hi_o(proc_state_hi_o),
		.proc_state_lo_o(proc_state_lo_o), .cpu_halt_o(cpu_halt_o),
		.bus_clk_run_o(bus_clk_run_o), .module_clk_run_o(module_clk_run_o)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask

	// classic cycle; request held until ack is sampled, then one idle cycle
	task automatic wb(input logic we, input logic [3:0] adr, input logic [7:0] d,
		input logic [3:0] sel);
		int k;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= {24'h000000, d};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		rd = wb_dat_o;
		if (wb_ack_o !== 1'b1)
			chk("wb_ack_o", 32'h1, 32'h0);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rdchk(input logic [3:0] adr, input logic [7:0] exp);
		wb(1'b0, adr, 8'h00, 4'hF);
		chk("wb_dat_o", {24'h000000, exp}, rd);
	endtask

	// pins hi, lo, cpu halt, bus clock run, then module run enables
	task automatic st(input logic [16:0] e);
		#1;
		chk("state_outputs", {15'h0, e}, {15'h0, proc_state_hi_o, proc_state_lo_o,
			cpu_halt_o, bus_clk_run_o, module_clk_run_o});
		@(posedge clk_i);
	endtask

	task automatic pul(input bit s);
		@(posedge clk_i);
		if (s)
			sleep_i <= 1'b1;
		else
			wake_i <= 1'b1;
		@(posedge clk_i);
		sleep_i <= 1'b0;
		wake_i <= 1'b0;
	endtask

	task automatic complete_run;
		if (n_fail == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock, watchdog, sequence
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	initial begin
		#50000;
		n_fail++;
		complete_run();
	end

	initial begin
		rst_i = 1'b1;
		manual_rst_i = 1'b0;
		sleep_i = 1'b0;
		wake_i = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		st({4'b1111, 13'h1FFF});
		repeat (2) @(posedge clk_i);
		st({4'b0001, 13'h1FFF});
		@(posedge clk_i);
		rdchk(`SMC_OFS_MODE, 8'h00);
		rdchk(`SMC_OFS_CORE, 8'h00);
		rdchk(`SMC_OFS_SER, 8'h00);
		foreach (rows[i]) begin
			wb(1'b1, rows[i].adr, rows[i].wd, 4'hF);
			rdchk(rows[i].adr, rows[i].rd);
			st({4'b0001, rows[i].run});
		end
		// sleep keeps module clocks, a second sleep and a wake in run are ignored
		wb(1'b1, `SMC_OFS_CORE, 8'h20, 4'hF);
		pul(1'b1);
		st({4'b1011, 13'h1FEF});
		pul(1'b1);
		st({4'b1011, 13'h1FEF});
		pul(1'b0);
		st({4'b0001, 13'h1FEF});
		pul(1'b0);
		st({4'b0001, 13'h1FEF});
		wb(1'b1, `SMC_OFS_MODE, 8'h80, 4'hF);
		pul(1'b1);
		st({4'b0110, 13'h0000});
		pul(1'b0);
		st({4'b0001, 13'h1FEF});
		@(posedge clk_i);
		wb(1'b1, `SMC_OFS_SER, 8'h05, 4'hF);
		wb(1'b1, `SMC_OFS_SER, 8'hFF, 4'hE);
		rdchk(`SMC_OFS_SER, 8'h05);
		// manual reset forces the reset state but keeps every register
		manual_rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		chk("state_pins", 32'h3, {30'h0, proc_state_hi_o, proc_state_lo_o});
		@(posedge clk_i);
		rdchk(`SMC_OFS_SER, 8'h05);
		rdchk(`SMC_OFS_MODE, 8'h80);
		manual_rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		st({4'b0001, 13'h0BEF});
		// power-on reset in mid-run clears all three registers
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdchk(`SMC_OFS_MODE, 8'h00);
		rdchk(`SMC_OFS_CORE, 8'h00);
		rdchk(`SMC_OFS_SER, 8'h00);
		st({4'b0001, 13'h1FFF});
		complete_run();
	end
endmodule
